// [rtl/rsf_consts.vh]
// Constants for the reset state and source flag block.
`ifndef RSF_CONSTS_VH
`define RSF_CONSTS_VH
`define RSF_ALL_ONES       8'hff
`define RSF_ZERO           8'h00
`define RSF_ASYNC_MODE_RST 8'h01
`define RSF_WDOG_EN_OPT0   8'h1a
`define RSF_WDOG_EN_OPT1   8'h9a
`define RSF_LVRF_BIT       0
`define RSF_WDRF_BIT       4
`define RSF_SRC_PIN        4'h1
`define RSF_SRC_PWRON      4'h2
`define RSF_SRC_WDOG       4'h4
`define RSF_SRC_LOWV       4'h8
`endif

// [rtl/rsf_reset_state.v]
// Reset state loader and reset source flags for peripheral registers.
`include "rsf_consts.vh"

module rsf_reset_state (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Reset requests from pin and detectors (asynchronous levels)
  input  wire       pin_reset_i,
  input  wire       power_on_clear_i,
  input  wire       watchdog_reset_i,
  input  wire       low_voltage_reset_i,
  // Option byte selection for the watchdog enable value
  input  wire       watchdog_option_i,
  // Software access to the reset source and detector registers
  input  wire       source_read_i,
  input  wire       lv_ctrl_we_i,
  input  wire       lv_level_we_i,
  input  wire [7:0] wdata_i,
  // Reset state outputs
  output reg        init_pulse_o,
  output reg  [7:0] reset_source_flags_o,
  output reg  [7:0] low_voltage_detect_ctrl_o,
  output reg  [7:0] low_voltage_level_select_o,
  output reg  [7:0] watchdog_enable_reg_o,
  output reg  [7:0] async_buffer_init_o,
  output reg  [7:0] async_port_mode_o,
  output reg  [7:0] async_status_init_o,
  output reg  [7:0] timer_h_init_o,
  output reg  [7:0] clocked_serial_init_o,
  output reg  [7:0] usb_interrupt_clear_o,
  output reg  [7:0] usb_interrupt_status_o,
  output reg  [7:0] usb_other_init_o,
  output reg  [7:0] interrupt_request_init_o,
  output reg  [7:0] interrupt_mask_init_o,
  output reg  [7:0] ext_edge_init_o
);
  // ----------------------------------------
  // Synchronised reset sources
  // ----------------------------------------
  wire [3:0] src_raw = {low_voltage_reset_i, watchdog_reset_i, power_on_clear_i, pin_reset_i};
  wire [3:0] src_sync;
  wire       opt_sync;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      rsf_sync2 u_sync (.clk_i(clk_i), .rst_i(rst_i), .d_i(src_raw[g]), .q_o(src_sync[g]));
    end
  endgenerate
  rsf_sync2 u_opt (.clk_i(clk_i), .rst_i(rst_i), .d_i(watchdog_option_i), .q_o(opt_sync));

  // ----------------------------------------
  // Reset tracking
  // ----------------------------------------
  // Two boot states let the synchronisers fill after the master reset, so the
  // option and source levels are valid before the first release.
  localparam [3:0] ST_BOOT0 = 4'b0001;
  localparam [3:0] ST_BOOT1 = 4'b0010;
  localparam [3:0] ST_HELD  = 4'b0100;
  localparam [3:0] ST_RUN   = 4'b1000;
  reg  [3:0] state_ff;
  reg  [3:0] nxt_state;
  reg  [3:0] seen_ff;
  reg  [3:0] nxt_seen;
  wire       any_src;
  wire       rel_now;
  wire       sw_open;
  assign any_src = |src_sync;
  assign rel_now = (state_ff == ST_HELD) & ~any_src;
  assign sw_open = (state_ff == ST_RUN) & ~any_src;
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_BOOT0: begin
        nxt_state = ST_BOOT1;
      end
      ST_BOOT1: begin
        nxt_state = ST_HELD;
      end
      ST_HELD: begin
        if (!any_src) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_src) begin
          nxt_state = ST_HELD;
        end
      end
      default: begin
        nxt_state = ST_HELD;
      end
    endcase
  end
  always @* begin
    nxt_seen = rel_now ? 4'h0 : (seen_ff | src_sync);
  end
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_BOOT0;
      seen_ff  <= `RSF_SRC_PWRON;
    end else begin
      state_ff <= nxt_state;
      seen_ff  <= nxt_seen;
    end
  end

  // ----------------------------------------
  // Reset source decode
  // ----------------------------------------
  // Pin or power-on clear dominates; watchdog and low voltage are decoded independently, with no priority between them.
  wire clr_all;
  wire by_wdog;
  wire by_lowv;
  assign clr_all = |(seen_ff & (`RSF_SRC_PIN | `RSF_SRC_PWRON));
  assign by_wdog = |(seen_ff & `RSF_SRC_WDOG);
  assign by_lowv = |(seen_ff & `RSF_SRC_LOWV);

  // ----------------------------------------
  // Reset source flags
  // ----------------------------------------
  reg  [7:0] nxt_flags;
  always @* begin
    nxt_flags = reset_source_flags_o;
    if (rel_now) begin
      if (clr_all) begin
        nxt_flags = `RSF_ZERO;
      end else begin
        nxt_flags[`RSF_WDRF_BIT] = by_wdog | reset_source_flags_o[`RSF_WDRF_BIT];
        nxt_flags[`RSF_LVRF_BIT] = by_lowv | reset_source_flags_o[`RSF_LVRF_BIT];
      end
    end else if (sw_open && source_read_i) begin
      nxt_flags = `RSF_ZERO;
    end
    nxt_flags[7:5] = 3'h0;
    nxt_flags[3:1] = 3'h0;
  end
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_source_flags_o <= `RSF_ZERO;
    end else begin
      reset_source_flags_o <= nxt_flags;
    end
  end

  // ----------------------------------------
  // Low-voltage detector registers
  // ----------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_voltage_detect_ctrl_o  <= `RSF_ZERO;
      low_voltage_level_select_o <= `RSF_ZERO;
    end else if (rel_now) begin
      if (clr_all | by_wdog) begin
        low_voltage_detect_ctrl_o  <= `RSF_ZERO;
        low_voltage_level_select_o <= `RSF_ZERO;
      end
    end else if (sw_open) begin
      if (lv_ctrl_we_i) begin
        low_voltage_detect_ctrl_o <= wdata_i;
      end
      if (lv_level_we_i) begin
        low_voltage_level_select_o <= wdata_i;
      end
    end
  end

  // ----------------------------------------
  // Release pulse and watchdog enable
  // ----------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      init_pulse_o          <= 1'b0;
      watchdog_enable_reg_o <= `RSF_WDOG_EN_OPT0;
    end else begin
      init_pulse_o <= rel_now;
      if (rel_now) begin
        watchdog_enable_reg_o <= opt_sync ? `RSF_WDOG_EN_OPT1 : `RSF_WDOG_EN_OPT0;
      end
    end
  end

  // ----------------------------------------
  // Peripheral initial values
  // ----------------------------------------
  // Contents that may be undefined after reset keep no state here.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      async_buffer_init_o      <= `RSF_ALL_ONES;
      async_port_mode_o        <= `RSF_ASYNC_MODE_RST;
      async_status_init_o      <= `RSF_ZERO;
      timer_h_init_o           <= `RSF_ZERO;
      clocked_serial_init_o    <= `RSF_ZERO;
      usb_interrupt_clear_o    <= `RSF_ALL_ONES;
      usb_interrupt_status_o   <= `RSF_ZERO;
      usb_other_init_o         <= `RSF_ZERO;
      interrupt_request_init_o <= `RSF_ZERO;
      interrupt_mask_init_o    <= `RSF_ALL_ONES;
      ext_edge_init_o          <= `RSF_ZERO;
    end else if (rel_now) begin
      async_buffer_init_o      <= `RSF_ALL_ONES;
      async_port_mode_o        <= `RSF_ASYNC_MODE_RST;
      async_status_init_o      <= `RSF_ZERO;
      timer_h_init_o           <= `RSF_ZERO;
      clocked_serial_init_o    <= `RSF_ZERO;
      usb_interrupt_clear_o    <= `RSF_ALL_ONES;
      usb_interrupt_status_o   <= `RSF_ZERO;
      usb_other_init_o         <= `RSF_ZERO;
      interrupt_request_init_o <= `RSF_ZERO;
      interrupt_mask_init_o    <= `RSF_ALL_ONES;
      ext_edge_init_o          <= `RSF_ZERO;
    end
  end
endmodule // rsf_reset_state

// [rtl/rsf_sync2.v]
// Two flip-flop synchroniser for one asynchronous level.
module rsf_sync2 (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Level
  input  wire d_i,
  output wire q_o
);
  reg meta_ff;
  reg sync_ff;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end
  assign q_o = sync_ff;
endmodule // rsf_sync2

// [tb/rsf_reset_state_sva.sv]
// Checker of reset initial values and reset source flags.
module rsf_reset_state_sva (
  input wire logic       clk_i, rst_i, pin_reset_i, power_on_clear_i, watchdog_reset_i,
  input wire logic       low_voltage_reset_i, source_read_i, init_pulse_o,
  input wire logic [7:0] reset_source_flags_o, watchdog_enable_reg_o, async_buffer_init_o, async_port_mode_o,
  input wire logic [7:0] async_status_init_o, timer_h_init_o, clocked_serial_init_o, usb_interrupt_clear_o,
  input wire logic [7:0] usb_interrupt_status_o, usb_other_init_o, interrupt_request_init_o,
  input wire logic [7:0] interrupt_mask_init_o, ext_edge_init_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence quiet_s;
    (!(pin_reset_i | power_on_clear_i | watchdog_reset_i | low_voltage_reset_i) && !init_pulse_o)[*4];
  endsequence
  AST_WATCHDOG_EN: assert property (init_pulse_o |-> watchdog_enable_reg_o inside {8'h1a, 8'h9a})
    else $error("watchdog enable value wrong");
  AST_ASYNC: assert property (init_pulse_o |-> {async_buffer_init_o, async_port_mode_o, async_status_init_o} == 24'hff0100)
    else $error("async port values wrong");
  AST_TIMER: assert property (init_pulse_o |-> timer_h_init_o == 8'h00)
    else $error("timer value wrong");
  AST_CLOCKED_SERIAL: assert property (init_pulse_o |-> clocked_serial_init_o == 8'h00)
    else $error("clocked serial value wrong");
  AST_USB: assert property (init_pulse_o |-> {usb_interrupt_clear_o, usb_interrupt_status_o} == 16'hff00)
    else $error("usb interrupt values wrong");
  AST_USB_OTHER: assert property (init_pulse_o |-> usb_other_init_o == 8'h00)
    else $error("usb other value wrong");
  AST_INTR: assert property (init_pulse_o |-> {interrupt_request_init_o, interrupt_mask_init_o, ext_edge_init_o} == 24'h00ff00)
    else $error("interrupt values wrong");
  AST_READ_CLR: assert property (quiet_s ##0 source_read_i |=> reset_source_flags_o == 8'h00)
    else $error("source read did not clear");
  AST_BITS: assert property ((reset_source_flags_o & 8'hee) == 8'h00)
    else $error("reserved flag bit set");
  AST_PULSE: assert property (init_pulse_o |=> !init_pulse_o)
    else $error("init pulse too long");
endmodule // rsf_reset_state_sva

// [tb/rsf_reset_state_tb_top.sv]
// Testbench of the reset state and source flag block.
module rsf_reset_state_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, pin_reset_i, power_on_clear_i, watchdog_reset_i, low_voltage_reset_i, watchdog_option_i;
  logic source_read_i, lv_ctrl_we_i, lv_level_we_i, init_pulse_o;
  logic [7:0] wdata_i, reset_source_flags_o, low_voltage_detect_ctrl_o, low_voltage_level_select_o,
    watchdog_enable_reg_o, async_buffer_init_o, async_port_mode_o, async_status_init_o, timer_h_init_o,
    clocked_serial_init_o, usb_interrupt_clear_o, usb_interrupt_status_o, usb_other_init_o,
    interrupt_request_init_o, interrupt_mask_init_o, ext_edge_init_o, wf, lf, c, l;
  logic [31:0] lfsr = 32'h5bfa4db1, q[$], got;
  int num_errors = 0, total_checks = 0, n;
  int n_k[6] = '{2, 3, 2, 1, 0, 3};
  rsf_reset_state u_dut (.*);
  function automatic [31:0] nxt(input [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic tally_and_finish;
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic step(input int k);
    lfsr = nxt(lfsr);
    @(posedge clk_i) begin watchdog_option_i <= lfsr[8]; lv_ctrl_we_i <= 1'b1; wdata_i <= lfsr[7:0]; end
    @(posedge clk_i) begin lv_ctrl_we_i <= 1'b0; lv_level_we_i <= 1'b1; wdata_i <= lfsr[23:16]; end
    @(posedge clk_i) lv_level_we_i <= 1'b0;
    c = lfsr[7:0]; l = lfsr[23:16];
    if (k < 2) {wf, lf, c, l} = 32'h0;
    if (k == 2) {wf, c, l} = {8'h01, 16'h0};
    if (k == 3) lf = 8'h01;
    q.push_back({lfsr[8] ? 8'h9a : 8'h1a, 3'b0, wf[0], 3'b0, lf[0], c, l});
    @(posedge clk_i) {pin_reset_i, power_on_clear_i, watchdog_reset_i, low_voltage_reset_i} <= 4'b1000 >> k;
    repeat (4) @(posedge clk_i);
    {pin_reset_i, power_on_clear_i, watchdog_reset_i, low_voltage_reset_i} <= 4'h0;
    for (n = 0; n < 20 && init_pulse_o !== 1'b1; n++) @(posedge clk_i);
    if (n == 20) begin
      num_errors++;
      $display("mismatch %0t no release pulse", $time);
    end
    repeat (3) @(posedge clk_i);
  endtask
  always @(posedge clk_i) if (!rst_i && init_pulse_o === 1'b1) begin
    got = {watchdog_enable_reg_o, reset_source_flags_o, low_voltage_detect_ctrl_o, low_voltage_level_select_o};
    total_checks++;
    if (q.size() == 0 || got !== q.pop_front()) begin
      num_errors++;
      $display("mismatch %0t reset state %h", $time, got);
    end
  end
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #20us num_errors++;
    tally_and_finish;
  end
  initial begin
    {rst_i, pin_reset_i, power_on_clear_i, watchdog_reset_i, low_voltage_reset_i} = 5'h10;
    {watchdog_option_i, source_read_i, lv_ctrl_we_i, lv_level_we_i, wdata_i} = 12'h0;
    {wf, lf} = 16'h0;
    q.push_back({8'h1a, 24'h0});
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    foreach (n_k[i]) step(n_k[i]);
    @(posedge clk_i) source_read_i <= 1'b1;
    @(posedge clk_i) source_read_i <= 1'b0;
    @(posedge clk_i) total_checks++;
    if (reset_source_flags_o !== 8'h00) begin
      num_errors++;
      $display("mismatch %0t read did not clear flags", $time);
    end
    if (q.size() != 0) begin
      num_errors++;
      $display("mismatch %0t expected reset state never shown", $time);
    end
    tally_and_finish;
  end
endmodule // rsf_reset_state_tb_top
bind rsf_reset_state rsf_reset_state_sva u_sva (.*);
